// [rtl/adc_result_monitor_cfg.svh]
/*
 Constants of the converter result monitor: register offsets, field positions, reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_RESULT_MONITOR_CFG_SVH
`define ADC_RESULT_MONITOR_CFG_SVH

`define ARM_OFS_CTRL0     12'h000
`define ARM_OFS_CTRL1     12'h004
`define ARM_OFS_COMPARE0  12'h008
`define ARM_OFS_COMPARE1  12'h00c
`define ARM_OFS_STATUS    12'h010
`define ARM_TGT_HI        11
`define ARM_TGT_LO        8
`define ARM_EN_BIT        7
`define ARM_POL_BIT       4
`define ARM_SEL_HI        3
`define ARM_SEL_LO        0
`define ARM_SEL_LAST      4'hb
`define ARM_CTRL_RESET    12'h000
`define ARM_CTRL_MASK     32'h00000f9f
`define ARM_CMP_RESET     12'h000
`define ARM_CNT_ONE       5'h01
`define ARM_CNT_ZERO      5'h00
`define ARM_IX_CTRL0      0
`define ARM_IX_CTRL1      1
`define ARM_IX_COMPARE0   2
`define ARM_IX_COMPARE1   3
`define ARM_IX_STATUS     4
`define ARM_DEC_NONE      5'h00

`endif

// [rtl/adc_result_monitor_pkg.sv]
/*
 Types of the converter result monitor.
 Needs no cfg header; the mode codes are written out as literals.
*/
package adc_result_monitor_pkg;
	typedef enum logic [1:0] {
		MODE_SINGLE_ONCE  = 2'h0,
		MODE_SINGLE_REPT  = 2'h1,
		MODE_SCAN_ONCE    = 2'h2,
		MODE_SCAN_REPT    = 2'h3
	} conv_mode_t;
endpackage

// [rtl/monitor_unit.sv]
/*
 One monitor unit: compare, count matches, pulse on the match after the count reaches the target.
 Assumes result strobes on clk_sys and a stable control word from the register file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_monitor_cfg.svh"

module monitor_unit #(
	parameter int RES_W = 12
) (
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             enable,
	input  wire logic             polarity,
	input  wire logic [3:0]       input_sel,
	input  wire logic [3:0]       target,
	input  wire logic [RES_W-1:0] compare_val,
	input  wire logic             mode_ok,
	input  wire logic             done,
	input  wire logic [3:0]       done_chan,
	input  wire logic [RES_W-1:0] result,
	output logic                  hit,
	output logic [4:0]            count
);
	logic [4:0] count_d, count_q;
	logic       hit_d, hit_q;
	logic       qualify;

	always_comb begin
		// Equal results qualify under neither polarity
		qualify = polarity ? (result < compare_val) : (result > compare_val);
		count_d = count_q;
		hit_d   = 1'b0;
		if (!enable) begin
			count_d = `ARM_CNT_ZERO;
		end else if (mode_ok && done && done_chan == input_sel && qualify) begin
			if (count_q + `ARM_CNT_ONE == {1'b0, target} + `ARM_CNT_ONE) begin
				hit_d   = 1'b1;
				count_d = `ARM_CNT_ZERO;
			end else begin
				count_d = count_q + `ARM_CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= `ARM_CNT_ZERO;
			hit_q   <= 1'b0;
		end else begin
			count_q <= count_d;
			hit_q   <= hit_d;
		end
	end

	assign hit   = hit_q;
	assign count = count_q;

	a_hit_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
		hit_q |-> count_q == `ARM_CNT_ZERO) else $error("count not cleared after hit");
	a_disable_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!enable |=> count_q == `ARM_CNT_ZERO && !hit_q) else $error("count kept while disabled");
	a_count_bound: assert property (@(posedge clk_sys) disable iff (!arst_n)
		count_q <= {1'b0, target}) else $error("count above target");
endmodule
`default_nettype wire

// [rtl/adc_result_monitor.sv]
/*
 Converter result monitor with two units and an APB register file.
 Assumes conversion strobes and the mode input come from converter logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_monitor_cfg.svh"

module adc_result_monitor #(
	parameter int RES_W = 12
) (
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [1:0]       conv_mode,
	input  wire logic             conv_done,
	input  wire logic [3:0]       conv_chan,
	input  wire logic [RES_W-1:0] conv_result,
	output logic                  monitor_irq_m0,
	output logic                  monitor_irq_m1
);
	////////////////////////////////////////////////////////////////
	logic [11:0]      ctrl0_d, ctrl0_q, ctrl1_d, ctrl1_q;
	logic [RES_W-1:0] cmp0_d, cmp0_q, cmp1_d, cmp1_q;
	logic [31:0]      rdata_d, rdata_q;
	logic             ready_d, ready_q, err_d, err_q;
	logic             hit0, hit1, mode_ok;
	logic [4:0]       count0, count1;
	logic [4:0]       addr_sel;
	logic             setup_phase;
	logic             write_go;

	function automatic logic [11:0] ctrl_wr(input logic [31:0] w);
		// Every select code is kept; codes past the last input just never meet a matching channel
		ctrl_wr = 12'(w & `ARM_CTRL_MASK);
	endfunction

	// One-hot register decode; an unmapped address leaves every bit low
	function automatic logic [4:0] reg_decode(input logic [11:0] a);
		reg_decode = `ARM_DEC_NONE;
		if (a == `ARM_OFS_CTRL0) begin
			reg_decode[`ARM_IX_CTRL0] = 1'b1;
		end else if (a == `ARM_OFS_CTRL1) begin
			reg_decode[`ARM_IX_CTRL1] = 1'b1;
		end else if (a == `ARM_OFS_COMPARE0) begin
			reg_decode[`ARM_IX_COMPARE0] = 1'b1;
		end else if (a == `ARM_OFS_COMPARE1) begin
			reg_decode[`ARM_IX_COMPARE1] = 1'b1;
		end else if (a == `ARM_OFS_STATUS) begin
			reg_decode[`ARM_IX_STATUS] = 1'b1;
		end
	endfunction

	assign mode_ok = conv_mode == adc_result_monitor_pkg::MODE_SINGLE_REPT
		|| conv_mode == adc_result_monitor_pkg::MODE_SCAN_REPT;

	////////////////////////////////////////////////////////////////
	// Bus answer: decoded in the setup cycle, so pready stands in the first access cycle
	assign setup_phase = psel && !penable;
	assign addr_sel    = reg_decode(paddr);
	// Writes land only at the access edge, the one at which the master samples pready
	assign write_go    = psel && penable && ready_q && pwrite;

	always_comb begin
		rdata_d = 32'h00000000;
		ready_d = 1'b0;
		err_d   = 1'b0;
		if (setup_phase) begin
			ready_d = 1'b1;
			if (pwrite) begin
				// Status is read-only, so a write to it is refused like an unmapped one
				err_d = addr_sel == `ARM_DEC_NONE || addr_sel[`ARM_IX_STATUS];
			end else if (addr_sel[`ARM_IX_CTRL0]) begin
				rdata_d = {20'h00000, ctrl0_q};
			end else if (addr_sel[`ARM_IX_CTRL1]) begin
				rdata_d = {20'h00000, ctrl1_q};
			end else if (addr_sel[`ARM_IX_COMPARE0]) begin
				rdata_d = 32'(cmp0_q);
			end else if (addr_sel[`ARM_IX_COMPARE1]) begin
				rdata_d = 32'(cmp1_q);
			end else if (addr_sel[`ARM_IX_STATUS]) begin
				rdata_d = {16'h0000, 3'h0, count1, 3'h0, count0};
			end else begin
				err_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 32'h00000000;
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q   <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control and compare registers; unmapped and status writes change nothing
	always_comb begin
		ctrl0_d = ctrl0_q;
		ctrl1_d = ctrl1_q;
		cmp0_d  = cmp0_q;
		cmp1_d  = cmp1_q;
		if (write_go) begin
			if (addr_sel[`ARM_IX_CTRL0]) begin
				ctrl0_d = ctrl_wr(pwdata);
			end else if (addr_sel[`ARM_IX_CTRL1]) begin
				ctrl1_d = ctrl_wr(pwdata);
			end else if (addr_sel[`ARM_IX_COMPARE0]) begin
				cmp0_d = pwdata[RES_W-1:0];
			end else if (addr_sel[`ARM_IX_COMPARE1]) begin
				cmp1_d = pwdata[RES_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl0_q <= `ARM_CTRL_RESET;
			ctrl1_q <= `ARM_CTRL_RESET;
			cmp0_q  <= RES_W'(`ARM_CMP_RESET);
			cmp1_q  <= RES_W'(`ARM_CMP_RESET);
		end else begin
			ctrl0_q <= ctrl0_d;
			ctrl1_q <= ctrl1_d;
			cmp0_q  <= cmp0_d;
			cmp1_q  <= cmp1_d;
		end
	end

	assign prdata  = rdata_q;
	assign pready  = ready_q;
	assign pslverr = err_q;

	////////////////////////////////////////////////////////////////
	monitor_unit #(.RES_W(RES_W)) u_mon0 (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.enable      (ctrl0_q[`ARM_EN_BIT]),
		.polarity    (ctrl0_q[`ARM_POL_BIT]),
		.input_sel   (ctrl0_q[`ARM_SEL_HI:`ARM_SEL_LO]),
		.target      (ctrl0_q[`ARM_TGT_HI:`ARM_TGT_LO]),
		.compare_val (cmp0_q),
		.mode_ok     (mode_ok),
		.done        (conv_done),
		.done_chan   (conv_chan),
		.result      (conv_result),
		.hit         (hit0),
		.count       (count0)
	);

	monitor_unit #(.RES_W(RES_W)) u_mon1 (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.enable      (ctrl1_q[`ARM_EN_BIT]),
		.polarity    (ctrl1_q[`ARM_POL_BIT]),
		.input_sel   (ctrl1_q[`ARM_SEL_HI:`ARM_SEL_LO]),
		.target      (ctrl1_q[`ARM_TGT_HI:`ARM_TGT_LO]),
		.compare_val (cmp1_q),
		.mode_ok     (mode_ok),
		.done        (conv_done),
		.done_chan   (conv_chan),
		.result      (conv_result),
		.hit         (hit1),
		.count       (count1)
	);

	// Hit pulses already come from unit flip-flops
	assign monitor_irq_m0 = hit0;
	assign monitor_irq_m1 = hit1;

	////////////////////////////////////////////////////////////////
	// Bus checks
	a_apb_ready: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && !penable
		|=> pready)
		else $error("no ready in access cycle");
	a_ready_single: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		pready
		|=> !pready)
		else $error("ready held too long");
	a_err_unmapped: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && !penable && !(paddr inside {`ARM_OFS_CTRL0, `ARM_OFS_CTRL1,
			`ARM_OFS_COMPARE0, `ARM_OFS_COMPARE1, `ARM_OFS_STATUS})
		|=> pslverr)
		else $error("unmapped access not refused");
	a_status_ro: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && !penable && pwrite && paddr == `ARM_OFS_STATUS
		|=> pslverr)
		else $error("status write not refused");
	a_err_quiet: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		pslverr
		|-> pready && prdata == 32'h00000000)
		else $error("error answer not clean");
	a_no_setup_write: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && !penable
		|=> $stable(ctrl0_q) && $stable(ctrl1_q) && $stable(cmp0_q) && $stable(cmp1_q))
		else $error("register changed at setup edge");
	a_ctrl_write: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && penable && pready && pwrite && paddr == `ARM_OFS_CTRL0
		|=> ctrl0_q[`ARM_TGT_HI:`ARM_TGT_LO] == $past(pwdata[`ARM_TGT_HI:`ARM_TGT_LO])
		&& ctrl0_q[`ARM_EN_BIT] == $past(pwdata[`ARM_EN_BIT]) && ctrl0_q[`ARM_POL_BIT] == $past(pwdata[`ARM_POL_BIT])
		&& ctrl0_q[`ARM_SEL_HI:`ARM_SEL_LO] == $past(pwdata[`ARM_SEL_HI:`ARM_SEL_LO]))
		else $error("ctrl0 write lost");
	a_ctrl1_write: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && penable && pready && pwrite && paddr == `ARM_OFS_CTRL1
		|=> ctrl1_q[`ARM_TGT_HI:`ARM_TGT_LO] == $past(pwdata[`ARM_TGT_HI:`ARM_TGT_LO])
		&& ctrl1_q[`ARM_EN_BIT] == $past(pwdata[`ARM_EN_BIT]) && ctrl1_q[`ARM_POL_BIT] == $past(pwdata[`ARM_POL_BIT])
		&& ctrl1_q[`ARM_SEL_HI:`ARM_SEL_LO] == $past(pwdata[`ARM_SEL_HI:`ARM_SEL_LO]))
		else $error("ctrl1 write lost");
	a_cmp_write: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && penable && pready && pwrite && paddr == `ARM_OFS_COMPARE0
		|=> cmp0_q == $past(pwdata[RES_W-1:0]))
		else $error("compare0 write lost");
	a_status_read: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		psel && !penable && !pwrite && paddr == `ARM_OFS_STATUS
		|=> prdata == {16'h0000, 3'h0, $past(count1), 3'h0, $past(count0)})
		else $error("status read wrong");

	// Monitor checks
	a_irq_needs_mode: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m0
		|-> $past(mode_ok) && $past(conv_done))
		else $error("irq without conversion");
	a_irq_mode_m1: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m1
		|-> $past(mode_ok) && $past(conv_done))
		else $error("m1 irq without conversion");
	a_irq_chan: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m1
		|-> $past(conv_chan) == $past(ctrl1_q[`ARM_SEL_HI:`ARM_SEL_LO]))
		else $error("irq on wrong input");
	a_irq_chan_m0: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m0
		|-> $past(conv_chan) == $past(ctrl0_q[`ARM_SEL_HI:`ARM_SEL_LO]))
		else $error("m0 irq on wrong input");
	a_irq_target: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m0
		|-> $past(count0) == {1'b0, $past(ctrl0_q[`ARM_TGT_HI:`ARM_TGT_LO])})
		else $error("irq before target");
	a_irq_target_m1: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m1
		|-> $past(count1) == {1'b0, $past(ctrl1_q[`ARM_TGT_HI:`ARM_TGT_LO])})
		else $error("m1 irq before target");
	a_irq_enabled: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m1
		|-> $past(ctrl1_q[`ARM_EN_BIT]))
		else $error("irq while disabled");
	a_irq_enabled_m0: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		monitor_irq_m0
		|-> $past(ctrl0_q[`ARM_EN_BIT]))
		else $error("m0 irq while disabled");
	a_count_step: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		count0 != $past(count0) && count0 != `ARM_CNT_ZERO
		|-> count0 == $past(count0) + `ARM_CNT_ONE
		&& $past(ctrl0_q[`ARM_POL_BIT]) == ($past(conv_result) < $past(cmp0_q)))
		else $error("bad count step");
	a_count_step_m1: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		count1 != $past(count1) && count1 != `ARM_CNT_ZERO
		|-> count1 == $past(count1) + `ARM_CNT_ONE
		&& $past(ctrl1_q[`ARM_POL_BIT]) == ($past(conv_result) < $past(cmp1_q)))
		else $error("bad m1 count step");
	a_mode_hold: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!mode_ok
		|=> (count0 == $past(count0) || count0 == `ARM_CNT_ZERO) && (count1 == $past(count1) || count1 == `ARM_CNT_ZERO))
		else $error("count moved outside repeat modes");
	a_off_clear_m1: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!ctrl1_q[`ARM_EN_BIT]
		|=> count1 == `ARM_CNT_ZERO && !monitor_irq_m1)
		else $error("m1 count kept while disabled");
endmodule
`default_nettype wire

// [bench/adc_result_monitor_test.sv]
/*
 Self-checking bench of the converter result monitor: APB register access and both monitor units.
 Assumes the cfg header offsets and an APB answer within 19 access cycles; the bench drives every port itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_monitor_cfg.svh"

module adc_result_monitor_test;
	logic        clk_sys;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  conv_mode;
	logic        conv_done;
	logic [3:0]  conv_chan;
	logic [11:0] conv_result;
	logic        monitor_irq_m0;
	logic        monitor_irq_m1;
	int          mismatches;
	int          n_compared;
	int          irq0_n;
	int          irq1_n;
	int          cycles;
	logic [31:0] rd;
	logic        err;

	adc_result_monitor #(.RES_W(12)) adc_result_monitor_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_mode(conv_mode), .conv_done(conv_done), .conv_chan(conv_chan),
		.conv_result(conv_result), .monitor_irq_m0(monitor_irq_m0), .monitor_irq_m1(monitor_irq_m1));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Counting high cycles also catches a pulse that stands longer than one cycle
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (monitor_irq_m0 === 1'b1) irq0_n <= irq0_n + 1;
		if (monitor_irq_m1 === 1'b1) irq1_n <= irq1_n + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
			mismatches = mismatches + 1;
		end
	endtask

	// Holds the request until pready is sampled high; a lost answer counts as a mismatch
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0, 32'h1, "apb answer missing");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, msg);
	endtask

	task automatic conv(input logic [3:0] ch, input logic [11:0] r);
		@(posedge clk_sys);
		conv_done <= 1'b1; conv_chan <= ch; conv_result <= r;
		@(posedge clk_sys);
		conv_done <= 1'b0; conv_result <= ~r;
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_regs();
		rdchk(`ARM_OFS_CTRL0, 32'h0, "ctrl0 reset");
		rdchk(`ARM_OFS_CTRL1, 32'h0, "ctrl1 reset");
		rdchk(`ARM_OFS_STATUS, 32'h0, "status reset");
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, `ARM_OFS_STATUS, 32'hffffffff);
		chk({31'h0, err}, 32'h1, "status write refused");
		rdchk(`ARM_OFS_STATUS, 32'h0, "status unchanged by write");
		apb(1'b1, `ARM_OFS_CTRL0, 32'hffffff7f);
		rdchk(`ARM_OFS_CTRL0, 32'h00000f1f, "ctrl0 writable bits");
		apb(1'b1, `ARM_OFS_CTRL0, 32'h0);
		$display("test regs done");
	endtask

	task automatic test_larger();
		apb(1'b1, `ARM_OFS_COMPARE0, 32'h100);
		rdchk(`ARM_OFS_COMPARE0, 32'h100, "compare0 readback");
		apb(1'b1, `ARM_OFS_CTRL0, 32'h285);
		conv(4'h5, 12'h101);
		conv(4'h5, 12'h100);
		conv(4'h4, 12'h3ff);
		conv(4'h5, 12'h0ff);
		rdchk(`ARM_OFS_STATUS, 32'h1, "one larger match");
		conv(4'h5, 12'hfff);
		settle();
		chk(irq0_n, 32'h0, "no irq before target");
		conv(4'h5, 12'h101);
		settle();
		chk(irq0_n, 32'h1, "irq at third match");
		rdchk(`ARM_OFS_STATUS, 32'h0, "count cleared after irq");
		$display("test larger done");
	endtask

	task automatic test_smaller_m1();
		conv_mode <= 2'h3;
		apb(1'b1, `ARM_OFS_COMPARE1, 32'h080);
		apb(1'b1, `ARM_OFS_CTRL1, 32'h0f9b);
		for (int i = 0; i < 15; i++) conv(4'hb, 12'h07f);
		conv(4'hb, 12'h080);
		settle();
		rdchk(`ARM_OFS_STATUS, 32'h0f00, "m1 fifteen smaller matches");
		chk(irq1_n, 32'h0, "m1 no irq before sixteen");
		conv(4'hb, 12'h000);
		settle();
		chk(irq1_n, 32'h1, "m1 irq at sixteen");
		chk(irq0_n, 32'h1, "m0 untouched by m1");
		$display("test smaller m1 done");
	endtask

	task automatic test_disable_mode();
		apb(1'b1, `ARM_OFS_CTRL1, 32'h0);
		conv_mode <= 2'h1;
		conv(4'h5, 12'h200);
		conv(4'h5, 12'h200);
		rdchk(`ARM_OFS_STATUS, 32'h2, "two matches");
		apb(1'b1, `ARM_OFS_CTRL0, 32'h205);
		rdchk(`ARM_OFS_STATUS, 32'h0, "disable clears count");
		conv(4'h5, 12'h200);
		rdchk(`ARM_OFS_STATUS, 32'h0, "no count while off");
		apb(1'b1, `ARM_OFS_CTRL0, 32'h285);
		conv(4'h5, 12'h200);
		conv(4'h5, 12'h200);
		conv_mode <= 2'h0;
		conv(4'h5, 12'h200);
		conv_mode <= 2'h2;
		conv(4'h5, 12'h200);
		settle();
		chk(irq0_n, 32'h1, "no count in once modes");
		conv_mode <= 2'h1;
		conv(4'h5, 12'h200);
		settle();
		chk(irq0_n, 32'h2, "irq after re-enable");
		$display("test disable mode done");
	endtask

	// A reset in mid-run must bring every register and output back to zero
	task automatic test_reset();
		apb(1'b1, `ARM_OFS_COMPARE1, 32'h0ab);
		apb(1'b1, `ARM_OFS_CTRL0, 32'h285);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk({30'h0, monitor_irq_m1, monitor_irq_m0}, 32'h0, "irq low in reset");
		arst_n <= 1'b1;
		rdchk(`ARM_OFS_CTRL0, 32'h0, "ctrl0 after reset");
		rdchk(`ARM_OFS_COMPARE1, 32'h0, "compare1 after reset");
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0; n_compared = 0; irq0_n = 0; irq1_n = 0; cycles = 0;
		arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
		conv_mode = 2'h1; conv_done = 1'b0; conv_chan = 4'h0; conv_result = 12'h000;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		test_regs();
		test_larger();
		test_smaller_m1();
		test_disable_mode();
		test_reset();
		conclude();
	end
endmodule
`default_nettype wire
